// file: design/ppd_parallel_port.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// How it works
// R01 - Reset leaves port A and port E data latches untouched.
// R02 - Port A driver is on when its direction bit is 1, off otherwise.
// R03 - Reset clears all four port A direction bits, pins become inputs.
// R04 - Port A read gives latch for outputs, sampled pin level for inputs.
// R05 - Data latches accept writes whatever the direction setting.
// R06 - Writing an input pin's latch only changes the stored latch value.
// R07 - Four port A pull-up bits; set pulls an input high, clear floats it.
// R08 - A pull-up is forced off while its pin is an output.
// R09 - Seven port D pull-up bits, active only while port D pin is input.
// R10 - Port E is two bits wide, both pins shared with the serial interface.
// R11 - Serial enable clear gives pins to port E; set gives them to serial.
// R12 - Port E direction bits never steer a pin the serial interface owns.
// R13 - Port E direction bits always choose latch or pin on read.
// R14 - Port E direction 1 drives the pin; reset clears both bits.
// R15 - Software should load the latch before turning a pin to output.
// R16 - Port A pins feed keyboard interrupt inputs when enabled there.
// R17 - Bits above each port's pin count read zero, writes ignored.
module ppd_parallel_port (
  // Clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset,
  // Avalon-MM slave
  input  wire ppd_pkg::ppd_av_req_t       i_avs_req,
  output ppd_pkg::ppd_av_rsp_t            o_avs_rsp,
  // Port A pins
  input  wire logic [ppd_pkg::PA_W-1:0]   i_pa_pin,
  output logic      [ppd_pkg::PA_W-1:0]   o_pa_out,
  output logic      [ppd_pkg::PA_W-1:0]   o_pa_oe_n,
  output logic      [ppd_pkg::PA_W-1:0]   o_pa_pullup,
  // Port D pull-up control
  input  wire logic [ppd_pkg::PD_W-1:0]   i_pd_dir,
  output logic      [ppd_pkg::PD_W-1:0]   o_pd_pullup,
  // Port E pins
  input  wire logic [ppd_pkg::PE_W-1:0]   i_pe_pin,
  output logic      [ppd_pkg::PE_W-1:0]   o_pe_out,
  output logic      [ppd_pkg::PE_W-1:0]   o_pe_oe_n,
  // Serial interface sharing
  input  wire logic                       i_serial_interface_enable,
  input  wire logic                       i_sci_txd,
  output logic                            o_sci_rxd,
  // Keyboard interrupt module
  input  wire logic [ppd_pkg::PA_W-1:0]   i_keyboard_interrupt_enables,
  output logic      [ppd_pkg::PA_W-1:0]   o_keyboard_inputs
);

  ////////////////////////////////////////////////////////////////////////////
  // Read-back select: latch where the pin drives, pin level where it listens
  function automatic logic [ppd_pkg::PA_W-1:0] read_mix(
    input logic [ppd_pkg::PA_W-1:0] latch,
    input logic [ppd_pkg::PA_W-1:0] pin,
    input logic [ppd_pkg::PA_W-1:0] dir
  );
    read_mix = (latch & dir) | (pin & ~dir);
  endfunction : read_mix

  ////////////////////////////////////////////////////////////////////////////
  // State
  ppd_pkg::ppd_state_t state_ff;
  ppd_pkg::ppd_state_t nxt_state;

  logic                       wr_lane0;
  logic                       rd_take;
  logic [ppd_pkg::REG_W-1:0]  wbyte;
  logic [ppd_pkg::REG_W-1:0]  rd_word;
  logic [ppd_pkg::PA_W-1:0]   pe_rd;
  logic                       serial_on;

  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_lane0  = i_avs_req.write & i_avs_req.byteenable[0];
  assign wbyte     = i_avs_req.writedata[ppd_pkg::REG_W-1:0];
  assign rd_take   = i_avs_req.read & ~state_ff.rd_valid;
  assign serial_on = i_serial_interface_enable;
  // Port E read uses its direction bits even under serial ownership
  assign pe_rd     = read_mix({2'h0, state_ff.pe_data},
                              {2'h0, state_ff.pe_s2},
                              {2'h0, state_ff.pe_dir}); // R13

  ////////////////////////////////////////////////////////////////////////////
  // Read decode, unmapped offsets return zero
  always_comb begin
    rd_word = 8'h00;
    case (i_avs_req.address)
      ppd_pkg::OFF_PA_DATA: begin
        rd_word = {4'h0, read_mix(state_ff.pa_data, state_ff.pa_s2,
                                  state_ff.pa_dir)}; // R04 R17
      end
      ppd_pkg::OFF_PA_DIR: begin
        rd_word = {4'h0, state_ff.pa_dir}; // R17
      end
      ppd_pkg::OFF_PA_PUE: begin
        rd_word = {4'h0, state_ff.pa_pue}; // R17
      end
      ppd_pkg::OFF_PD_PUE: begin
        rd_word = {1'b0, state_ff.pd_pue}; // R17
      end
      ppd_pkg::OFF_PE_DATA: begin
        rd_word = {6'h00, pe_rd[ppd_pkg::PE_W-1:0]}; // R10 R17
      end
      ppd_pkg::OFF_PE_DIR: begin
        rd_word = {6'h00, state_ff.pe_dir}; // R17
      end
      default: begin
        rd_word = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: writes, synchronisers, read pipeline, reset
  always_comb begin
    nxt_state = state_ff;
    // Two-stage synchronisers for the pin levels
    nxt_state.pa_s1 = i_pa_pin;
    nxt_state.pa_s2 = state_ff.pa_s1;
    nxt_state.pe_s1 = i_pe_pin;
    nxt_state.pe_s2 = state_ff.pe_s1;
    // One wait cycle per read so read data come from a flop
    nxt_state.rd_valid = rd_take;
    if (rd_take) begin
      nxt_state.rdata = rd_word;
    end
    // Writes land at the edge where waitrequest is low (always, for writes)
    if (wr_lane0) begin
      case (i_avs_req.address)
        ppd_pkg::OFF_PA_DATA: begin
          nxt_state.pa_data = wbyte[ppd_pkg::PA_W-1:0]; // R05 R06 R17
        end
        ppd_pkg::OFF_PA_DIR: begin
          nxt_state.pa_dir = wbyte[ppd_pkg::PA_W-1:0]; // R17
        end
        ppd_pkg::OFF_PA_PUE: begin
          nxt_state.pa_pue = wbyte[ppd_pkg::PA_W-1:0]; // R07 R17
        end
        ppd_pkg::OFF_PD_PUE: begin
          nxt_state.pd_pue = wbyte[ppd_pkg::PD_W-1:0]; // R09 R17
        end
        ppd_pkg::OFF_PE_DATA: begin
          nxt_state.pe_data = wbyte[ppd_pkg::PE_W-1:0]; // R05 R17
        end
        ppd_pkg::OFF_PE_DIR: begin
          nxt_state.pe_dir = wbyte[ppd_pkg::PE_W-1:0]; // R17
        end
        default: begin
          nxt_state.rd_valid = rd_take;
        end
      endcase
    end
    // Reset clears control and the read pipeline; data latches keep whatever they held
    if (i_reset) begin
      nxt_state.pa_dir   = ppd_pkg::RST_PA_DIR; // R03 R01
      nxt_state.pe_dir   = ppd_pkg::RST_PE_DIR; // R14 R01
      nxt_state.pa_pue   = ppd_pkg::RST_PA_PUE;
      nxt_state.pd_pue   = ppd_pkg::RST_PD_PUE;
      nxt_state.rd_valid = 1'b0;
      nxt_state.rdata    = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk) begin
    state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: writes complete at once, reads after one wait cycle
  assign o_avs_rsp.waitrequest = i_avs_req.read & ~state_ff.rd_valid;
  assign o_avs_rsp.readdata    = {24'h000000, state_ff.rdata};

  ////////////////////////////////////////////////////////////////////////////
  // Port A pad control; loading the latch first avoids a glitch on turn-on
  assign o_pa_out    = state_ff.pa_data; // R15
  assign o_pa_oe_n   = ~state_ff.pa_dir; // R02
  assign o_pa_pullup = state_ff.pa_pue & ~state_ff.pa_dir; // R07 R08

  ////////////////////////////////////////////////////////////////////////////
  // Port D pull-ups follow the port D direction from the port D logic
  assign o_pd_pullup = state_ff.pd_pue & ~i_pd_dir; // R09 R08

  ////////////////////////////////////////////////////////////////////////////
  // Port E pads; serial ownership overrides the direction bits
  always_comb begin
    o_pe_out  = state_ff.pe_data;
    o_pe_oe_n = ~state_ff.pe_dir; // R14
    if (serial_on) begin
      o_pe_out[ppd_pkg::PE_TXD_BIT]  = i_sci_txd; // R11 R12
      o_pe_oe_n[ppd_pkg::PE_TXD_BIT] = 1'b0; // R11 R12
      o_pe_out[ppd_pkg::PE_RXD_BIT]  = 1'b0; // R12
      o_pe_oe_n[ppd_pkg::PE_RXD_BIT] = 1'b1; // R11 R12
    end
  end

  // Receive line idles high while the serial interface is off
  assign o_sci_rxd = serial_on ? state_ff.pe_s2[ppd_pkg::PE_RXD_BIT]
                               : 1'b1; // R11

  ////////////////////////////////////////////////////////////////////////////
  // Keyboard inputs: synchronised pin levels, gated by the enables
  assign o_keyboard_inputs = state_ff.pa_s2 &
                             i_keyboard_interrupt_enables; // R16

endmodule : ppd_parallel_port

// file: design/ppd_pkg.sv
package ppd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port widths
  localparam int PA_W  = 4;
  localparam int PD_W  = 7;
  localparam int PE_W  = 2;
  localparam int REG_W = 8;
  localparam int AV_AW = 5;
  localparam int AV_DW = 32;
  localparam int AV_BW = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [AV_AW-1:0] OFF_PA_DATA = 5'h00;
  localparam logic [AV_AW-1:0] OFF_PA_DIR  = 5'h04;
  localparam logic [AV_AW-1:0] OFF_PA_PUE  = 5'h08;
  localparam logic [AV_AW-1:0] OFF_PD_PUE  = 5'h0c;
  localparam logic [AV_AW-1:0] OFF_PE_DATA = 5'h10;
  localparam logic [AV_AW-1:0] OFF_PE_DIR  = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of control fields (data latches have none)
  localparam logic [PA_W-1:0] RST_PA_DIR = 4'h0;
  localparam logic [PA_W-1:0] RST_PA_PUE = 4'h0;
  localparam logic [PD_W-1:0] RST_PD_PUE = 7'h00;
  localparam logic [PE_W-1:0] RST_PE_DIR = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Port E pin positions shared with the serial interface
  localparam int PE_TXD_BIT = 0;
  localparam int PE_RXD_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus carriers and block state
  typedef struct packed {
    logic             read;
    logic             write;
    logic [AV_AW-1:0] address;
    logic [AV_DW-1:0] writedata;
    logic [AV_BW-1:0] byteenable;
  } ppd_av_req_t;

  typedef struct packed {
    logic             waitrequest;
    logic [AV_DW-1:0] readdata;
  } ppd_av_rsp_t;

  typedef struct packed {
    logic [PA_W-1:0]  pa_data;
    logic [PA_W-1:0]  pa_dir;
    logic [PA_W-1:0]  pa_pue;
    logic [PD_W-1:0]  pd_pue;
    logic [PE_W-1:0]  pe_data;
    logic [PE_W-1:0]  pe_dir;
    logic [PA_W-1:0]  pa_s1;
    logic [PA_W-1:0]  pa_s2;
    logic [PE_W-1:0]  pe_s1;
    logic [PE_W-1:0]  pe_s2;
    logic             rd_valid;
    logic [REG_W-1:0] rdata;
  } ppd_state_t;

endpackage : ppd_pkg

// file: tb/ppd_parallel_port_properties.sv
`timescale 1ns/1ps
module ppd_parallel_port_properties (
  // Clock and reset
  input wire logic                 i_sys_clk,
  input wire logic                 i_reset,
  // Register bus
  input wire ppd_pkg::ppd_av_req_t i_avs_req,
  input wire ppd_pkg::ppd_av_rsp_t o_avs_rsp,
  // Pins
  input wire logic [3:0]           o_pa_out,
  input wire logic [3:0]           o_pa_oe_n,
  input wire logic [3:0]           o_pa_pullup,
  input wire logic [1:0]           o_pe_out,
  input wire logic [1:0]           o_pe_oe_n,
  input wire logic                 i_serial_interface_enable,
  input wire logic                 i_sci_txd
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Lane 0 write decode; other lanes never reach a register
  function automatic logic hit(ppd_pkg::ppd_av_req_t r, logic [4:0] o);
    return r.write && r.byteenable[0] && r.address == o;
  endfunction : hit
  // Each property ties an output to the access, reset release or serial enable that caused it
  property p_wr; i_avs_req.write |-> !o_avs_rsp.waitrequest; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rd;
    $rose(i_avs_req.read) |-> o_avs_rsp.waitrequest ##1 !o_avs_rsp.waitrequest;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_hi;
    i_avs_req.read && !o_avs_rsp.waitrequest |-> o_avs_rsp.readdata[31:8] == 0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_rst; $fell(i_reset) && !i_serial_interface_enable |->
    o_pa_oe_n == 4'hf && o_pe_oe_n == 2'h3 && o_pa_pullup == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs");
  property p_dir; hit(i_avs_req, ppd_pkg::OFF_PA_DIR) |=>
    o_pa_oe_n == ~$past(i_avs_req.writedata[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("port a driver wrong");
  property p_out; hit(i_avs_req, ppd_pkg::OFF_PA_DATA) |=>
    o_pa_out == $past(i_avs_req.writedata[3:0]); endproperty
  a_out: assert property (p_out) else $error("latch write lost");
  property p_pue; hit(i_avs_req, ppd_pkg::OFF_PA_PUE) |=>
    o_pa_pullup == ($past(i_avs_req.writedata[3:0]) & o_pa_oe_n); endproperty
  a_pue: assert property (p_pue) else $error("pull-up wrong");
  property p_ser; i_serial_interface_enable |->
    o_pe_oe_n == 2'h2 && o_pe_out[0] == i_sci_txd; endproperty
  a_ser: assert property (p_ser) else $error("serial pins wrong");
  // Main scenarios
  c_rd: cover property (i_avs_req.read && !o_avs_rsp.waitrequest);
  c_pu: cover property (|o_pa_pullup);
  c_ser: cover property (i_serial_interface_enable);
endmodule : ppd_parallel_port_properties
////////////////////////////////////////////////////////////////////////////
bind ppd_parallel_port ppd_parallel_port_properties
  ppd_parallel_port_properties_i (.i_sys_clk, .i_reset, .i_avs_req,
  .o_avs_rsp, .o_pa_out, .o_pa_oe_n, .o_pa_pullup, .o_pe_out, .o_pe_oe_n,
  .i_serial_interface_enable, .i_sci_txd);

// file: tb/ppd_pin_model.sv
`timescale 1ns/1ps
module ppd_pin_model #(parameter int W = 6) (
  // Clock
  input wire logic         i_clk,
  // Device side
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe_n,
  input wire logic [W-1:0] i_pull,
  // External drivers
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext_val,
  output logic     [W-1:0] o_pin
);
  // A floating pin wanders so a stale level never passes for a read
  logic [W-1:0] wander_ff = '0;
  // Plain always: the initialiser above would be a second writer under ff
  always @(posedge i_clk) wander_ff <= ~wander_ff;
  // Device driver wins, then external, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!i_oe_n[i]) o_pin[i] = i_out[i];
      else if (i_ext_en[i]) o_pin[i] = i_ext_val[i];
      else if (i_pull[i]) o_pin[i] = 1'b1;
      else o_pin[i] = wander_ff[i];
    end
  end
endmodule : ppd_pin_model

// file: tb/ppd_parallel_port_tb_top.sv
`timescale 1ns/1ps
module ppd_parallel_port_tb_top;
  // Stimulus and observed signals
  logic i_sys_clk = 1'b0, i_reset = 1'b1, sen = 1'b0, txd = 1'b0, rxd;
  ppd_pkg::ppd_av_req_t req = '0;
  ppd_pkg::ppd_av_rsp_t rsp;
  logic [3:0] pa_pin, pa_out, pa_oe_n, pa_pull, kb_in, kb_en = 4'h5;
  logic [6:0] pd_dir = 7'h0f, pd_pull;
  logic [1:0] pe_pin, pe_out, pe_oe_n;
  logic [5:0] ext_en = 6'h3f, ext_val = 6'h1a;
  logic [7:0] rd;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  ppd_parallel_port ppd_parallel_port_i (.i_sys_clk, .i_reset,
    .i_avs_req(req), .o_avs_rsp(rsp), .i_pa_pin(pa_pin), .o_pa_out(pa_out),
    .o_pa_oe_n(pa_oe_n), .o_pa_pullup(pa_pull), .i_pd_dir(pd_dir),
    .o_pd_pullup(pd_pull), .i_pe_pin(pe_pin), .o_pe_out(pe_out),
    .o_pe_oe_n(pe_oe_n), .i_serial_interface_enable(sen), .i_sci_txd(txd),
    .o_sci_rxd(rxd), .i_keyboard_interrupt_enables(kb_en),
    .o_keyboard_inputs(kb_in));
  ppd_pin_model ppd_pin_model_i (.i_clk(i_sys_clk), .i_out({pe_out, pa_out}),
    .i_oe_n({pe_oe_n, pa_oe_n}), .i_pull({2'h0, pa_pull}), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pin({pe_pin, pa_pin}));
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // A stuck handshake ends here rather than hanging the run
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // Request held until waitrequest is sampled low
  task av(input logic w, input logic [4:0] a, input logic [7:0] d,
          input logic b);
    @(posedge i_sys_clk);
    req <= '{read: !w, write: w, address: a, writedata: {24'h0, d},
             byteenable: {3'h0, b}};
    do @(posedge i_sys_clk); while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata[7:0];
    req <= '0;
  endtask : av
  task wr(input logic [4:0] a, input logic [7:0] d);
    av(1'b1, a, d, 1'b1);
  endtask : wr
  // Settling first covers the two-stage pin synchroniser
  task rc(input logic [4:0] a, input logic [7:0] e);
    repeat (3) @(posedge i_sys_clk);
    av(1'b0, a, 8'h00, 1'b1);
    chk($sformatf("register %h", a), rd, e);
  endtask : rc
  task rst4;
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
  endtask : rst4
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst4;
    rc(ppd_pkg::OFF_PA_DIR, 8'h00);
    rc(ppd_pkg::OFF_PE_DIR, 8'h00);
    rc(ppd_pkg::OFF_PA_PUE, 8'h00);
    wr(ppd_pkg::OFF_PA_DATA, 8'h35);
    rc(ppd_pkg::OFF_PA_DATA, 8'h0a);
    chk("pa_out", 8'(pa_out), 8'h05);
    wr(ppd_pkg::OFF_PA_DIR, 8'hff);
    rc(ppd_pkg::OFF_PA_DIR, 8'h0f);
    rc(ppd_pkg::OFF_PA_DATA, 8'h05);
    chk("pa_oe_n", 8'(pa_oe_n), 8'h00);
    $display("port a test done");
    rst4;
    wr(ppd_pkg::OFF_PA_DIR, 8'h03);
    rc(ppd_pkg::OFF_PA_DATA, 8'h09);
    ext_en <= 6'h30;
    wr(ppd_pkg::OFF_PA_PUE, 8'hff);
    rc(ppd_pkg::OFF_PA_DATA, 8'h0d);
    chk("pa_pullup", 8'(pa_pull), 8'h0c);
    chk("kb_in", 8'(kb_in), 8'h05);
    wr(ppd_pkg::OFF_PD_PUE, 8'hff);
    av(1'b1, ppd_pkg::OFF_PD_PUE, 8'h00, 1'b0);
    rc(ppd_pkg::OFF_PD_PUE, 8'h7f);
    chk("pd_pullup", 8'(pd_pull), 8'h70);
    rc(5'h18, 8'h00);
    $display("pull-up test done");
    wr(ppd_pkg::OFF_PE_DATA, 8'h02);
    rc(ppd_pkg::OFF_PE_DATA, 8'h01);
    wr(ppd_pkg::OFF_PE_DIR, 8'h03);
    rc(ppd_pkg::OFF_PE_DATA, 8'h02);
    chk("pe_out", 8'(pe_out), 8'h02);
    sen <= 1'b1;
    txd <= 1'b1;
    rc(ppd_pkg::OFF_PE_DATA, 8'h02);
    chk("pe_oe_n", 8'(pe_oe_n), 8'h02);
    chk("rxd", 8'(rxd), 8'h00);
    wr(ppd_pkg::OFF_PE_DIR, 8'h00);
    rc(ppd_pkg::OFF_PE_DATA, 8'h01);
    sen <= 1'b0;
    @(negedge i_sys_clk);
    chk("rxd", 8'(rxd), 8'h01);
    $display("port e test done");
    tally_and_finish;
  end
endmodule : ppd_parallel_port_tb_top
